// file: gpio_function_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_function_mapper
  import gpio_map_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input  wire logic                 SYS_CLK_IN,
  input  wire logic                 SYS_RST_IN,
  input  wire logic [7:0]           AWADDR_IN,
  input  wire logic                 AWVALID_IN,
  output logic                      AWREADY_OUT,
  input  wire logic [31:0]          WDATA_IN,
  input  wire logic [3:0]           WSTRB_IN,
  input  wire logic                 WVALID_IN,
  output logic                      WREADY_OUT,
  output logic [1:0]                BRESP_OUT,
  output logic                      BVALID_OUT,
  input  wire logic                 BREADY_IN,
  input  wire logic [7:0]           ARADDR_IN,
  input  wire logic                 ARVALID_IN,
  output logic                      ARREADY_OUT,
  output logic [31:0]               RDATA_OUT,
  output logic [1:0]                RRESP_OUT,
  output logic                      RVALID_OUT,
  input  wire logic                 RREADY_IN,
  input  wire logic                 PIN_IN,
  output logic                      PIN_OUT,
  output logic                      PIN_OE_OUT,
  input  wire logic [7:0]           STATUS_SRC_IN,
  output gpio_map_pkg::pulse_t      ACTION_OUT,
  output logic                      DEVICE_RESET_OUT
);
  import gpio_map_pkg::*;

  logic [31:0] cfg;
  logic [CHANNELS-1:0] vpdn, ipdn, fgen, mhi;
  logic nvm_ok, wr_ok;
  logic s1, s2, s3;
  logic booted;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  pulse_t next_act, act_q;

  // pin synchroniser; s1 read only by s2
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= PIN_IN;
      s2 <= s1;
      s3 <= s2;
    end
  end

  wire         in_en    = cfg[CFG_IN_EN];
  wire         out_en   = cfg[CFG_OUT_EN];
  wire func_t  func     = func_t'(cfg[CFG_FUNC_LO +: 4]);
  wire [CHANNELS-1:0] sel  = cfg[CFG_SEL_LO +: CHANNELS];
  wire [CHANNELS-1:0] sync = cfg[CFG_SYNC_LO +: CHANNELS];
  wire [3:0]   osel     = cfg[CFG_OSEL_LO +: 4];
  wire         active   = in_en && !out_en;
  wire         fall     = active && booted && s3 && !s2;
  wire         rise     = active && booted && !s3 && s2;
  wire         boot_evt = active && !booted;
  wire         lvl_lo   = boot_evt && !s2;
  wire         lvl_hi   = boot_evt && s2;
  wire         do_lo    = fall || lvl_lo;
  wire         do_hi    = rise || lvl_hi;
  // boot level uses s2, so a pin already low at mapping acts once

  // bus
  wire aw_ok = aw_hold || AWVALID_IN;
  wire w_ok  = w_hold || WVALID_IN;
  wire wr_go = aw_ok && w_ok && !BVALID_OUT;
  wire [7:0]  wa = aw_hold ? aw_addr : AWADDR_IN;
  wire [31:0] wd = w_hold ? w_data : WDATA_IN;
  wire [3:0]  ws = w_hold ? w_strb : WSTRB_IN;
  wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire hit_cfg  = wa == ADDR_CONFIG;
  wire hit_trig = wa == ADDR_TRIG;
  wire hit_wp   = wa == ADDR_WPROT;
  wire mapped   = hit_cfg || hit_trig || hit_wp || wa == ADDR_STATUS || wa == ADDR_ACTION;
  // write lock: unlock and i2c reset writes pass, marked via WPROT word
  wire wp_pass  = hit_wp && (wd[WP_UNLOCK] || wd[WP_RESET]);
  wire wr_allow = wr_ok || wp_pass;
  wire do_write = wr_go && wr_allow;
  wire [31:0] next_cfg = (cfg & ~wmask) | (wd & wmask);
  wire sw_trig  = do_write && hit_trig;
  wire [31:0] status_word = {13'h0, s2, wr_ok, nvm_ok,
                             4'(mhi), 4'(fgen), 4'(ipdn), 4'(vpdn)};

  assign AWREADY_OUT = !aw_hold && !BVALID_OUT;
  assign WREADY_OUT  = !w_hold && !BVALID_OUT;
  assign ARREADY_OUT = !RVALID_OUT;

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      aw_hold    <= 1'b0;
      w_hold     <= 1'b0;
      aw_addr    <= 8'h00;
      w_data     <= 32'h0000_0000;
      w_strb     <= 4'h0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT  <= 2'b00;
    end else begin
      if (wr_go) begin
        aw_hold    <= 1'b0;
        w_hold     <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT  <= mapped ? (wr_allow ? 2'b00 : 2'b10) : 2'b11;
      end else begin
        if (AWVALID_IN && AWREADY_OUT) begin
          aw_hold <= 1'b1;
          aw_addr <= AWADDR_IN;
        end
        if (WVALID_IN && WREADY_OUT) begin
          w_hold <= 1'b1;
          w_data <= WDATA_IN;
          w_strb <= WSTRB_IN;
        end
        if (BVALID_OUT && BREADY_IN) begin
          BVALID_OUT <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RVALID_OUT <= 1'b0;
      RDATA_OUT  <= 32'h0000_0000;
      RRESP_OUT  <= 2'b00;
    end else if (ARVALID_IN && ARREADY_OUT) begin
      RVALID_OUT <= 1'b1;
      RRESP_OUT  <= 2'b00;
      case (ARADDR_IN)
        ADDR_CONFIG: RDATA_OUT <= cfg;
        ADDR_STATUS: RDATA_OUT <= status_word;
        ADDR_ACTION: RDATA_OUT <= {23'h0, act_q};
        ADDR_TRIG,
        ADDR_WPROT:  RDATA_OUT <= 32'h0000_0000;
        default: begin
          RDATA_OUT <= 32'h0000_0000;
          RRESP_OUT <= 2'b11;
        end
      endcase
    end else if (RVALID_OUT && RREADY_IN) begin
      RVALID_OUT <= 1'b0;
    end
  end

  // cfg is volatile: a pin reset clears it, including a reset mapping
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cfg <= CFG_RESET;
    end else if (act_q.act[TR_RST]) begin
      cfg <= CFG_RESET;
    end else if (do_write && hit_cfg) begin
      cfg <= next_cfg;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      booted <= 1'b0;
    end else if (active) begin
      booted <= 1'b1;
    end
  end

  // software trigger masked when the pin owns the function
  wire pin_snap = active && func == FN_SNAP;
  wire pin_prot = active && func == FN_PROT;
  wire pin_clr  = active && func == FN_CLR;
  wire pin_load = active && func == FN_LOAD;
  wire pin_rst  = active && func == FN_RST;

  always_comb begin
    next_act = '0;
    next_act.act[TR_SNAP] = (pin_snap && do_lo) || (sw_trig && wd[TR_SNAP] && !pin_snap);
    next_act.act[TR_PROT] = (pin_prot && do_lo) || (sw_trig && wd[TR_PROT] && !pin_prot);
    next_act.act[TR_CLR]  = (pin_clr && do_lo) || (sw_trig && wd[TR_CLR] && !pin_clr);
    // low pulse: reset fires on the falling edge that starts it
    next_act.act[TR_RST]  = (pin_rst && fall) || (sw_trig && wd[TR_RST] && !pin_rst);
    next_act.load_ch = (pin_load && do_lo) ? sel & sync :
                       ((sw_trig && wd[TR_LOAD] && !pin_load) ? sync : '0);
    next_act.act[TR_LOAD] = |next_act.load_ch;
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      act_q <= '0;
    end else begin
      act_q <= next_act;
    end
  end

  assign ACTION_OUT       = act_q;
  assign DEVICE_RESET_OUT = act_q.act[TR_RST];

  // per-channel state
  wire fn_v = active && func == FN_VPDN;
  wire fn_i = active && func == FN_IPDN;
  wire fn_f = active && func == FN_FGEN;
  wire fn_m = active && func == FN_MARG;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
          vpdn[g] <= 1'b0;
          ipdn[g] <= 1'b0;
          fgen[g] <= 1'b0;
          mhi[g]  <= 1'b0;
        end else if (sel[g]) begin
          if (fn_v && (do_lo || do_hi)) begin
            vpdn[g] <= do_lo;
          end
          if (fn_i && (do_lo || do_hi)) begin
            ipdn[g] <= do_lo;
          end
          if (fn_f && (do_lo || do_hi)) begin
            fgen[g] <= do_hi;
          end
          if (fn_m && (do_lo || do_hi)) begin
            mhi[g] <= do_hi;
          end
        end
      end
    end
  endgenerate

  // gates default open; pin codes 1100/1101 close them on a high level
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      nvm_ok <= 1'b1;
      wr_ok  <= 1'b1;
    end else begin
      if (active && func == FN_NVM && (do_lo || do_hi)) begin
        nvm_ok <= do_lo;
      end
      if (active && func == FN_WLCK && (do_lo || do_hi)) begin
        wr_ok <= do_lo;
      end
    end
  end

  // status output: codes 0001 and 0100..1011 select a status input bit
  wire st_valid = osel == 4'h1 || (osel >= 4'h4 && osel <= 4'hB);
  wire st_bit   = osel == 4'h1 ? STATUS_SRC_IN[0] : STATUS_SRC_IN[3'(osel - 4'h4)];
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      PIN_OUT    <= 1'b0;
      PIN_OE_OUT <= 1'b0;
    end else begin
      PIN_OE_OUT <= out_en;
      PIN_OUT    <= st_valid && st_bit;
    end
  end

  AST_VPDN_FALL: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    (fall && fn_v && sel[0] && !act_q.act[TR_RST]) |=> vpdn[0]) else $error("vout powerdown missed");
  AST_MARG_RISE: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    (rise && fn_m && sel[0]) |=> mhi[0]) else $error("margin high missed");
  AST_CH_UNSEL: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    (!sel[1]) |=> $stable(vpdn[1]) && $stable(fgen[1])) else $error("unselected channel changed");
  AST_RST_FALL: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    (fall && pin_rst) |=> DEVICE_RESET_OUT ##1 (cfg == CFG_RESET)) else $error("pin reset missed");
  AST_RST_RISE: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    (rise && pin_rst && !sw_trig) |=> !DEVICE_RESET_OUT) else $error("rise caused reset");
  AST_SW_MASK: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    (pin_clr && !fall && !lvl_lo) |=> !act_q.act[TR_CLR]) else $error("sw clear not masked");
  AST_LOAD_SYNC: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    (pin_load && fall) |=> (act_q.load_ch == $past(sel & sync))) else $error("load channels wrong");
  AST_WLOCK: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    (!wr_ok && wr_go && hit_cfg) |=> $stable(cfg) && BRESP_OUT == 2'b10) else $error("locked write landed");
  AST_OE: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    out_en |=> PIN_OE_OUT) else $error("output enable lost");
  AST_UNMAPPED: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    (!active && !sw_trig) |=> (act_q == '0)) else $error("idle pin acted");
endmodule
`default_nettype wire

// file: gpio_function_mapper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_function_mapper_tb;
  import gpio_map_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, want = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, src = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic        awready, wready, bvalid, arready, rvalid, pin, pin_o, pin_oe, dev_rst;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  lch = 4'h0, sel, syn;
  pulse_t      act;
  int          failures = 0, tests_run = 0, seed = 32'h0000_97cc, rcnt = 0, b0;
  int          pcnt[5] = '{0, 0, 0, 0, 0};
  logic [3:0]  gc[3] = '{4'h2, 4'h5, 4'h7};
  logic [3:0]  cc[4] = '{4'h3, 4'h4, 4'h9, 4'hA};
  int          cf[4] = '{ST_IPDN_LO, ST_VPDN_LO, ST_FGEN_LO, ST_MHI_LO};
  bit          cfall[4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  always #25 clk = ~clk;
  gpio_pin_partner drv (.clk_in(clk), .want_in(want), .pin_out(pin));
  gpio_function_mapper dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
    .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(4'hF), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
    .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .PIN_IN(pin), .PIN_OUT(pin_o), .PIN_OE_OUT(pin_oe), .STATUS_SRC_IN(src), .ACTION_OUT(act),
    .DEVICE_RESET_OUT(dev_rst));

  // pulses last one cycle, so they are counted here rather than polled
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) if (act.act[i] === 1'b1) pcnt[i]++;
    if (act.act[TR_LOAD] === 1'b1) lch <= act.load_ch;
    if (dev_rst === 1'b1) rcnt++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tmo(input bit busy);
    if (busy) begin
      failures++;
      $display("MISMATCH bus_wait expected answer seen timeout");
      end_sim;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] r);
    bit busy = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && busy; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        busy = 1'b0;
      end
    end
    tmo(busy);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] r);
    bit busy = 1'b1;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && busy; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        dat = rdata;
        r = rresp;
        rready <= 1'b0;
        busy = 1'b0;
      end
    end
    tmo(busy);
  endtask
  task automatic reset_dut;
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  // covers partner lag, two-flop synchroniser and the action register
  task automatic setpin(input logic v);
    @(posedge clk);
    want <= v;
    repeat (14) @(posedge clk);
  endtask
  task automatic map(input logic [3:0] fn, input logic [3:0] s, input logic [3:0] y);
    wr(ADDR_CONFIG, {4'h0, y, 15'h0000, s, fn, 1'b1}, resp);
    repeat (14) @(posedge clk);
  endtask
  function automatic int psum();
    return pcnt[0] + pcnt[1] + pcnt[2] + pcnt[3] + pcnt[4];
  endfunction
  // status code 0001 and 0100..1011 pick a source bit, others drive low
  function automatic logic exp_pin(input int c, input logic [7:0] s);
    if (c == 1) return s[0];
    if (c >= 4 && c <= 11) return s[c-4];
    return 1'b0;
  endfunction

  initial begin
    reset_dut;
    rd(ADDR_CONFIG, d, resp);
    chk("config_reset", d, CFG_RESET);
    rd(8'h14, d, resp);
    chk("unmapped_resp", {30'h0000_0000, resp}, 32'h0000_0003);
    chk("unmapped_data", d, 32'h0000_0000);
    b0 = psum();
    wr(ADDR_TRIG, 32'h0000_0007, resp);
    repeat (4) @(posedge clk);
    chk("sw_trig", psum() - b0, 3);
    chk("oe_idle", {30'h0000_0000, pin_oe, pin_o}, 32'h0000_0000);
    b0 = psum();
    setpin(1'b0);
    setpin(1'b1);
    chk("idle_pin", psum(), b0);
    $display("test defaults done");
    for (int i = 0; i < 3; i++) begin
      reset_dut;
      setpin(1'b0);
      b0 = pcnt[i];
      map(gc[i], 4'h0, 4'h0);
      chk("boot_level", pcnt[i] - b0, 1);
      setpin(1'b1);
      chk("rise_none", pcnt[i] - b0, 1);
      setpin(1'b0);
      chk("fall_act", pcnt[i] - b0, 2);
      wr(ADDR_TRIG, 32'h0000_0007, resp);
      repeat (4) @(posedge clk);
      chk("sw_ignored", pcnt[i] - b0, 2);
    end
    $display("test global done");
    for (int i = 0; i < 4; i++) begin
      reset_dut;
      setpin(1'b1);
      sel = 4'($random(seed)) | 4'h1;
      map(cc[i], sel, 4'h0);
      setpin(1'b0);
      rd(ADDR_STATUS, d, resp);
      chk("chan_fall", (d >> cf[i]) & 32'h0000_000F, cfall[i] ? sel : 4'h0);
      setpin(1'b1);
      rd(ADDR_STATUS, d, resp);
      chk("chan_rise", (d >> cf[i]) & 32'h0000_000F, cfall[i] ? 4'h0 : sel);
    end
    $display("test channel done");
    reset_dut;
    setpin(1'b1);
    sel = 4'($random(seed)) | 4'h1;
    syn = 4'($random(seed)) | 4'h1;
    map(4'h8, sel, syn);
    b0 = pcnt[TR_LOAD];
    setpin(1'b0);
    chk("load_fall", pcnt[TR_LOAD] - b0, 1);
    chk("load_chans", lch, sel & syn);
    setpin(1'b1);
    chk("load_rise", pcnt[TR_LOAD] - b0, 1);
    $display("test load done");
    reset_dut;
    setpin(1'b1);
    map(4'hB, 4'h0, 4'h0);
    b0 = rcnt;
    setpin(1'b0);
    setpin(1'b1);
    chk("pin_reset", rcnt - b0, 1);
    rd(ADDR_CONFIG, d, resp);
    chk("map_lost", d, CFG_RESET);
    setpin(1'b0);
    setpin(1'b1);
    chk("reset_gone", rcnt - b0, 1);
    $display("test reset done");
    reset_dut;
    setpin(1'b1);
    map(4'hD, 4'h0, 4'h0);
    wr(ADDR_TRIG, 32'h0000_0000, resp);
    chk("locked", {30'h0000_0000, resp}, 32'h0000_0002);
    wr(ADDR_CONFIG, 32'h0000_0000, resp);
    chk("locked_cfg", {30'h0000_0000, resp}, 32'h0000_0002);
    rd(ADDR_CONFIG, d, resp);
    chk("cfg_kept", d, {27'h000_0000, 4'hD, 1'b1});
    wr(ADDR_WPROT, 32'h0000_0002, resp);
    chk("reset_key", {30'h0000_0000, resp}, 32'h0000_0000);
    wr(ADDR_WPROT, 32'h0000_0001, resp);
    chk("unlock_key", {30'h0000_0000, resp}, 32'h0000_0000);
    setpin(1'b0);
    wr(ADDR_TRIG, 32'h0000_0000, resp);
    chk("unlocked", {30'h0000_0000, resp}, 32'h0000_0000);
    $display("test lock done");
    reset_dut;
    setpin(1'b1);
    map(4'hC, 4'h0, 4'h0);
    rd(ADDR_STATUS, d, resp);
    chk("nvm_block", d[ST_NVM_OK], 32'h0000_0000);
    setpin(1'b0);
    rd(ADDR_STATUS, d, resp);
    chk("nvm_allow", d[ST_NVM_OK], 32'h0000_0001);
    $display("test nvm done");
    reset_dut;
    src <= 8'($random(seed));
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_CONFIG, 32'h0000_2000 | (32'(c) << CFG_OSEL_LO), resp);
      repeat (4) @(posedge clk);
      chk("pin_drive", {30'h0000_0000, pin_oe, pin_o}, {30'h0000_0000, 1'b1, exp_pin(c, src)});
    end
    $display("test output done");
    end_sim;
  end
endmodule
`default_nettype wire

// file: gpio_map_pkg.sv
package gpio_map_pkg;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_TRIG   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ACTION = 8'h0C;
  localparam logic [7:0] ADDR_WPROT  = 8'h10;
  // config word fields
  localparam int CFG_IN_EN   = 0;
  localparam int CFG_FUNC_LO = 1;
  localparam int CFG_SEL_LO  = 5;
  localparam int CFG_OSEL_LO = 9;
  localparam int CFG_OUT_EN  = 13;
  localparam int CFG_PDN_LO  = 16;
  localparam int CFG_SYNC_LO = 24;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // status word fields
  localparam int ST_VPDN_LO = 0;
  localparam int ST_IPDN_LO = 4;
  localparam int ST_FGEN_LO = 8;
  localparam int ST_MHI_LO  = 12;
  localparam int ST_NVM_OK  = 16;
  localparam int ST_WR_OK   = 17;
  localparam int ST_LEVEL   = 18;
  // write-protect: bit 0 unlock write, bit 1 reset write over i2c
  localparam int WP_UNLOCK = 0;
  localparam int WP_RESET  = 1;
  // trigger bits: same positions in sw trigger word and action pulses
  localparam int TR_SNAP  = 0;
  localparam int TR_PROT  = 1;
  localparam int TR_CLR   = 2;
  localparam int TR_LOAD  = 3;
  localparam int TR_RST   = 4;
  localparam int TR_WIDTH = 5;
  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_SNAP = 4'h2, FN_IPDN = 4'h3, FN_VPDN = 4'h4, FN_PROT = 4'h5,
    FN_CLR = 4'h7, FN_LOAD = 4'h8, FN_FGEN = 4'h9, FN_MARG = 4'hA, FN_RST = 4'hB,
    FN_NVM = 4'hC, FN_WLCK = 4'hD
  } func_t;
  typedef struct packed {
    logic [TR_WIDTH-1:0] act;
    logic [3:0]          load_ch;
  } pulse_t;
endpackage

// file: gpio_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_partner (
  input  wire logic clk_in,
  input  wire logic want_in,
  output logic      pin_out
);
  int   seed = 32'h0000_97cc;
  int   lag;
  // pulled high on the board, so idle level is one
  logic lvl  = 1'b1;
  assign pin_out = lvl;
  // follows the request after zero to three cycles, prompt or slow
  always @(posedge clk_in) begin
    if (want_in !== lvl) begin
      lag = {$random(seed)} % 4;
      repeat (lag) @(posedge clk_in);
      lvl <= want_in;
    end
  end
endmodule
`default_nettype wire
